// File: src/iaoc_cond.sv
/*
 iaoc_cond: evaluates the selected interlock condition of one channel.
 Assumes: vehicle state already synchronised; purely combinational.
*/
`timescale 1ns/1ps
module iaoc_cond (
	// vehicle state and channel settings
	input iaoc_pkg::iaoc_vehicle_t vehicle,
	input wire logic [4:0] condSel,
	input wire logic [7:0] speedThr,
	input wire logic [7:0] gearThr,
	// result
	output logic condOk
);
	import iaoc_pkg::*;

	logic [16:0] condTable;
	wire isStopped = (vehicle.speed == SPEED_STOPPED);
	wire isNeutral = (vehicle.gear == GEAR_NEUTRAL);
	wire selValid = (condSel <= COND_NOT_NEUTRAL);

	// one predicate per selector code
	assign condTable[COND_NONE] = 1'b1;
	assign condTable[COND_BRAKE_SET] = vehicle.parkBrake;
	assign condTable[COND_BRAKE_OFF] = !vehicle.parkBrake;
	assign condTable[COND_DOOR_OPEN] = vehicle.doorOpen;
	assign condTable[COND_DOORS_SHUT] = !vehicle.doorOpen;
	assign condTable[COND_PTO_ON] = vehicle.powerTakeoffEngaged;
	assign condTable[COND_PTO_OFF] = !vehicle.powerTakeoffEngaged;
	assign condTable[COND_ENG_RUN] = vehicle.engineRunning;
	assign condTable[COND_ENG_STOP] = !vehicle.engineRunning;
	assign condTable[COND_SPEED_ABOVE] = vehicle.speed > speedThr;
	assign condTable[COND_SPEED_BELOW] = vehicle.speed < speedThr;
	assign condTable[COND_STOPPED] = isStopped;
	assign condTable[COND_MOVING] = !isStopped;
	assign condTable[COND_GEAR_ABOVE] = vehicle.gear > gearThr;
	assign condTable[COND_GEAR_BELOW] = vehicle.gear < gearThr;
	assign condTable[COND_NEUTRAL] = isNeutral;
	assign condTable[COND_NOT_NEUTRAL] = !isNeutral;

	// unknown selector codes hold the output off
	assign condOk = selValid ? condTable[condSel] : 1'b0;
endmodule : iaoc_cond

// File: src/iaoc_pkg.sv
/*
 iaoc_pkg: shared constants and types of the interlocked auxiliary output controller:
 register offsets, configuration and status layouts, reset values, interlock selector
 codes, gear coding and the channel state encoding.
 Assumes: included before every other file of the block; no other package is needed.
*/
package iaoc_pkg;

	// channel count and bus geometry
	localparam int NUM_CH = 2;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [11:0] OFF_CFG0 = 12'h000;
	localparam logic [11:0] OFF_LIM0 = 12'h004;
	localparam logic [11:0] OFF_CFG1 = 12'h008;
	localparam logic [11:0] OFF_LIM1 = 12'h00C;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_INPUTS = 12'h014;
	localparam logic [11:0] CH_STRIDE = 12'h008;

	// per-channel configuration word
	typedef struct packed {
		logic [7:0] gearThr;
		logic [7:0] speedThr;
		logic [1:0] shedPri;
		logic latchEn;
		logic [4:0] condSel;
	} iaoc_cfg_t;

	localparam int CFG_W = 24;
	localparam int LIMIT_W = 8;
	localparam int MEAS_W = 8;

	// defaults: neutral gear, 30 mph, shed level 1, no latch, selector 10
	localparam iaoc_cfg_t CFG_RESET = '{gearThr: 8'h7D, speedThr: 8'h1E, shedPri: 2'h1,
		latchEn: 1'b0, condSel: 5'h0A};
	// current limit in tenths of an ampere, 20.0 A
	localparam logic [7:0] LIMIT_RESET = 8'hC8;

	// vehicle state as seen after synchronisation
	typedef struct packed {
		logic parkBrake;
		logic doorOpen;
		logic powerTakeoffEngaged;
		logic engineRunning;
		logic [7:0] speed;
		logic [7:0] gear;
	} iaoc_vehicle_t;

	localparam int VEH_W = 20;

	// per-channel status byte
	typedef struct packed {
		logic [2:0] spare;
		logic switchOn;
		logic condOk;
		logic fused;
		logic latched;
		logic on;
	} iaoc_status_t;

	// interlock selector codes
	localparam logic [4:0] COND_NONE = 5'h00;
	localparam logic [4:0] COND_BRAKE_SET = 5'h01;
	localparam logic [4:0] COND_BRAKE_OFF = 5'h02;
	localparam logic [4:0] COND_DOOR_OPEN = 5'h03;
	localparam logic [4:0] COND_DOORS_SHUT = 5'h04;
	localparam logic [4:0] COND_PTO_ON = 5'h05;
	localparam logic [4:0] COND_PTO_OFF = 5'h06;
	localparam logic [4:0] COND_ENG_RUN = 5'h07;
	localparam logic [4:0] COND_ENG_STOP = 5'h08;
	localparam logic [4:0] COND_SPEED_ABOVE = 5'h09;
	localparam logic [4:0] COND_SPEED_BELOW = 5'h0A;
	localparam logic [4:0] COND_STOPPED = 5'h0B;
	localparam logic [4:0] COND_MOVING = 5'h0C;
	localparam logic [4:0] COND_GEAR_ABOVE = 5'h0D;
	localparam logic [4:0] COND_GEAR_BELOW = 5'h0E;
	localparam logic [4:0] COND_NEUTRAL = 5'h0F;
	localparam logic [4:0] COND_NOT_NEUTRAL = 5'h10;

	// gear coding: neutral, forward above, reverse below
	localparam logic [7:0] GEAR_NEUTRAL = 8'h7D;
	localparam logic [7:0] GEAR_FIRST_FWD = 8'h7E;
	localparam logic [7:0] SPEED_STOPPED = 8'h00;
	localparam logic [1:0] SHED_NONE = 2'h0;

	// channel state, one-hot
	typedef enum logic [3:0] {
		CH_OFF = 4'b0001,
		CH_ON = 4'b0010,
		CH_LATCHED = 4'b0100,
		CH_FUSED = 4'b1000
	} iaoc_state_t;

endpackage : iaoc_pkg

// File: src/iaoc_sync.sv
/*
 iaoc_sync: two-stage synchroniser for a bundle of pin inputs.
 Assumes: each bit is a slowly changing level; multi-bit values are only sampled
 by consumers that tolerate one cycle of skew between bits.
*/
`timescale 1ns/1ps
module iaoc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pin side and clock side
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : iaoc_sync

// File: src/iaoc_top.sv
/*
 iaoc_top: two-channel interlocked auxiliary load output controller with an APB
 register slave, pin synchronisers, per-channel state machines and checks.
 Assumes: all vehicle, switch, current and shed inputs come from outside the clock
 domain; the APB master follows the usual setup and access phases.
*/
// Functional notes
// - unlatched drop returns when condition comes back
// - latched drop stays off despite condition
// - latch released only by switch off-on
// - speed threshold used only at 9, 10
// - gear threshold used only at 13, 14
// - gear code 125 neutral, offsets fwd/rev
// - current above limit trips the channel off
// - selector 0 applies no interlock
// - selectors 1, 2 follow park brake
// - selectors 3, 4 follow door state
// - selectors 5, 6 follow power take-off
// - selectors 7, 8 follow engine running
// - selectors 9, 10 compare speed threshold
// - selectors 11, 12 stopped or moving
// - selectors 13, 14 compare gear threshold
// - selectors 15, 16 neutral or not
// - shed level 0 exempt, 1 first, 3 last
// - two fully independent channels
// - outputs only with key permitted
`timescale 1ns/1ps
module iaoc_top (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// operator and key pins
	input wire logic [iaoc_pkg::NUM_CH-1:0] switchOn,
	input wire logic ignitionKeyOn,
	// vehicle state pins
	input wire logic parkBrake,
	input wire logic doorOpen,
	input wire logic powerTakeoffEngaged,
	input wire logic engineRunning,
	input wire logic [7:0] vehicleSpeed,
	input wire logic [7:0] transmissionGear,
	// measured current per channel, tenths of an ampere
	input wire logic [iaoc_pkg::NUM_CH-1:0][7:0] loadCurrent,
	// load shed request level
	input wire logic [1:0] shedRequest,
	// load driver
	output logic [iaoc_pkg::NUM_CH-1:0] loadOn
);
	import iaoc_pkg::*;

	localparam int PIN_W = NUM_CH + 1 + VEH_W + 2 + NUM_CH * MEAS_W;

	logic [PIN_W-1:0] pinRaw;
	logic [PIN_W-1:0] pinSync;
	logic [NUM_CH-1:0] swSync;
	logic keySync;
	iaoc_vehicle_t vehSync;
	logic [1:0] shedSync;
	logic [NUM_CH-1:0][7:0] currSync;

	iaoc_cfg_t cfgReg [NUM_CH];
	logic [7:0] limitReg [NUM_CH];
	iaoc_state_t chState [NUM_CH];
	iaoc_state_t next_chState [NUM_CH];
	logic [NUM_CH-1:0] condOk;
	logic [NUM_CH-1:0] shedOn;
	logic [NUM_CH-1:0] overLimit;
	logic [NUM_CH-1:0] permit;
	logic [NUM_CH-1:0] allOk;
	iaoc_status_t chStatus [NUM_CH];
	logic [31:0] next_prdata;
	logic next_pslverr;

	// shed applies when level is nonzero and not above the request
	function automatic logic shedHit(input logic [1:0] pri, input logic [1:0] req);
		return (pri != SHED_NONE) && (pri <= req);
	endfunction : shedHit

	// bundle every pin through one synchroniser
	assign pinRaw = {switchOn, ignitionKeyOn, parkBrake, doorOpen, powerTakeoffEngaged,
		engineRunning, vehicleSpeed, transmissionGear, shedRequest, loadCurrent};

	iaoc_sync #(
		.W(PIN_W)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.din(pinRaw),
		.dout(pinSync)
	);

	// unpack synchronised pins
	assign {swSync, keySync, vehSync, shedSync, currSync} = pinSync;

	// apb decode
	wire setupPhase = psel && !penable;
	wire wrAccess = psel && penable && pwrite;
	wire hitCfg0 = (paddr == OFF_CFG0);
	wire hitLim0 = (paddr == OFF_LIM0);
	wire hitCfg1 = (paddr == OFF_CFG1);
	wire hitLim1 = (paddr == OFF_LIM1);
	wire hitStatus = (paddr == OFF_STATUS);
	wire hitInputs = (paddr == OFF_INPUTS);
	wire hitAny = hitCfg0 || hitLim0 || hitCfg1 || hitLim1 || hitStatus || hitInputs;
	wire [31:0] statusWord = 32'({chStatus[1], chStatus[0]});
	wire [31:0] inputsWord = 32'({shedSync, keySync, vehSync});

	// zero wait states
	assign pready = 1'b1;

	// read mux, evaluated in the setup phase
	always_comb begin
		next_prdata = '0;
		if (hitCfg0) begin
			next_prdata = 32'(cfgReg[0]);
		end else if (hitLim0) begin
			next_prdata = 32'(limitReg[0]);
		end else if (hitCfg1) begin
			next_prdata = 32'(cfgReg[1]);
		end else if (hitLim1) begin
			next_prdata = 32'(limitReg[1]);
		end else if (hitStatus) begin
			next_prdata = statusWord;
		end else if (hitInputs) begin
			next_prdata = inputsWord;
		end
		next_pslverr = !hitAny;
	end

	// read data and error are held for the access phase
	always_ff @(posedge clock) begin
		if (rst) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (setupPhase) begin
			prdata <= pwrite ? '0 : next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// every check runs on the one clock, quiet during reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// per-channel logic, no shared state between channels
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			wire hitCfg = (paddr == 12'(OFF_CFG0 + CH_STRIDE * ch));
			wire hitLim = (paddr == 12'(OFF_LIM0 + CH_STRIDE * ch));
			wire swOn = swSync[ch];

			// configuration registers
			always_ff @(posedge clock) begin
				if (rst) begin
					cfgReg[ch] <= CFG_RESET;
					limitReg[ch] <= LIMIT_RESET;
				end else if (wrAccess && hitCfg) begin
					cfgReg[ch] <= iaoc_cfg_t'(pwdata[CFG_W-1:0]);
				end else if (wrAccess && hitLim) begin
					limitReg[ch] <= pwdata[LIMIT_W-1:0];
				end
			end

			iaoc_cond u_cond (
				.vehicle(vehSync),
				.condSel(cfgReg[ch].condSel),
				.speedThr(cfgReg[ch].speedThr),
				.gearThr(cfgReg[ch].gearThr),
				.condOk(condOk[ch])
			);

			// permits that do not depend on the interlock, then allOk that adds the interlock
			assign shedOn[ch] = shedHit(cfgReg[ch].shedPri, shedSync);
			assign overLimit[ch] = currSync[ch] > limitReg[ch];
			assign permit[ch] = swOn && keySync && !shedOn[ch] && !overLimit[ch];
			assign allOk[ch] = permit[ch] && condOk[ch];

			// channel state machine
			always_comb begin
				next_chState[ch] = chState[ch];
				case (chState[ch])
					CH_OFF: begin
						if (allOk[ch]) begin
							next_chState[ch] = CH_ON;
						end
					end
					CH_ON: begin
						if (!swOn || !keySync || shedOn[ch]) begin
							next_chState[ch] = CH_OFF;
						end else if (overLimit[ch]) begin
							next_chState[ch] = CH_FUSED;
						end else if (!condOk[ch]) begin
							next_chState[ch] = cfgReg[ch].latchEn ? CH_LATCHED : CH_OFF;
						end
					end
					CH_LATCHED: begin
						if (!swOn) begin
							next_chState[ch] = CH_OFF;
						end
					end
					CH_FUSED: begin
						if (!swOn) begin
							next_chState[ch] = CH_OFF;
						end
					end
					default: begin
						next_chState[ch] = CH_OFF;
					end
				endcase
			end

			// state register
			always_ff @(posedge clock) begin
				if (rst) begin
					chState[ch] <= CH_OFF;
				end else begin
					chState[ch] <= next_chState[ch];
				end
			end

			// output straight from the state register, status from state, switch and interlock
			assign loadOn[ch] = (chState[ch] == CH_ON);
			assign chStatus[ch] = '{spare: 3'h0, switchOn: swOn, condOk: condOk[ch],
				fused: chState[ch] == CH_FUSED, latched: chState[ch] == CH_LATCHED,
				on: loadOn[ch]};

			// checks
			wire [4:0] sel = cfgReg[ch].condSel;

			sequence sDropFree;
				chState[ch] == CH_ON && permit[ch] && !condOk[ch] && !cfgReg[ch].latchEn;
			endsequence

			sequence sDropLatched;
				chState[ch] == CH_ON && permit[ch] && !condOk[ch] && cfgReg[ch].latchEn;
			endsequence

			AST_RECOVER: assert property (sDropFree |=> chState[ch] == CH_OFF)
				else $error("unlatched interlock drop did not go to off");
			AST_RETURN: assert property (chState[ch] == CH_OFF && allOk[ch]
				|=> loadOn[ch])
				else $error("output did not return after interlock recovered");
			AST_LATCH_HOLD: assert property (sDropLatched ##1 swOn [*3]
				|-> !loadOn[ch] && chState[ch] == CH_LATCHED)
				else $error("latched output came back while switch stayed on");
			AST_LATCH_RELEASE: assert property (chState[ch] == CH_LATCHED && !swOn
				|=> chState[ch] == CH_OFF)
				else $error("latch not released by switch off");
			AST_SPEED_IGNORED: assert property ($changed(cfgReg[ch].speedThr)
				&& $stable(cfgReg[ch].gearThr) && $stable(sel) && $stable(vehSync)
				&& sel != COND_SPEED_ABOVE && sel != COND_SPEED_BELOW
				|-> $stable(condOk[ch]))
				else $error("speed threshold affected an unrelated selector");
			AST_GEAR_IGNORED: assert property ($changed(cfgReg[ch].gearThr)
				&& $stable(cfgReg[ch].speedThr) && $stable(sel) && $stable(vehSync)
				&& sel != COND_GEAR_ABOVE && sel != COND_GEAR_BELOW
				|-> $stable(condOk[ch]))
				else $error("gear threshold affected an unrelated selector");
			AST_GEAR_CODE: assert property (sel == COND_GEAR_ABOVE
				&& cfgReg[ch].gearThr == GEAR_NEUTRAL && vehSync.gear == GEAR_FIRST_FWD
				|-> condOk[ch])
				else $error("first forward gear not above neutral");
			AST_FUSE: assert property (overLimit[ch] |=> !loadOn[ch] ##1 !loadOn[ch])
				else $error("output stayed on above current limit");
			AST_NO_INTERLOCK: assert property (sel == COND_NONE |-> condOk[ch])
				else $error("selector 0 blocked the output");
			AST_BRAKE: assert property ((sel == COND_BRAKE_SET
				|-> condOk[ch] == vehSync.parkBrake)
				and (sel == COND_BRAKE_OFF |-> condOk[ch] != vehSync.parkBrake))
				else $error("park brake interlock wrong");
			AST_DOOR: assert property ((sel == COND_DOOR_OPEN
				|-> condOk[ch] == vehSync.doorOpen)
				and (sel == COND_DOORS_SHUT |-> condOk[ch] != vehSync.doorOpen))
				else $error("door interlock wrong");
			AST_PTO: assert property ((sel == COND_PTO_ON
				|-> condOk[ch] == vehSync.powerTakeoffEngaged)
				and (sel == COND_PTO_OFF |-> condOk[ch] != vehSync.powerTakeoffEngaged))
				else $error("power take-off interlock wrong");
			AST_ENGINE: assert property ((sel == COND_ENG_RUN
				|-> condOk[ch] == vehSync.engineRunning)
				and (sel == COND_ENG_STOP |-> condOk[ch] != vehSync.engineRunning))
				else $error("engine interlock wrong");
			AST_SPEED: assert property ((sel == COND_SPEED_ABOVE
				|-> condOk[ch] == (vehSync.speed > cfgReg[ch].speedThr))
				and (sel == COND_SPEED_BELOW
				|-> condOk[ch] == (vehSync.speed < cfgReg[ch].speedThr)))
				else $error("speed interlock wrong");
			AST_MOTION: assert property ((sel == COND_STOPPED
				|-> condOk[ch] == (vehSync.speed == SPEED_STOPPED))
				and (sel == COND_MOVING |-> condOk[ch] == (vehSync.speed != SPEED_STOPPED)))
				else $error("stopped or moving interlock wrong");
			AST_GEAR: assert property ((sel == COND_GEAR_ABOVE
				|-> condOk[ch] == (vehSync.gear > cfgReg[ch].gearThr))
				and (sel == COND_GEAR_BELOW
				|-> condOk[ch] == (vehSync.gear < cfgReg[ch].gearThr)))
				else $error("gear interlock wrong");
			AST_NEUTRAL: assert property ((sel == COND_NEUTRAL
				|-> condOk[ch] == (vehSync.gear == GEAR_NEUTRAL))
				and (sel == COND_NOT_NEUTRAL |-> condOk[ch] == (vehSync.gear != GEAR_NEUTRAL)))
				else $error("neutral interlock wrong");
			AST_SHED_LEVEL: assert property ((cfgReg[ch].shedPri == SHED_NONE
				|-> !shedOn[ch]) and (cfgReg[ch].shedPri != SHED_NONE
				&& shedSync == 2'h3 |-> shedOn[ch]))
				else $error("shed priority decode wrong");
			AST_INDEPENDENT: assert property ($stable(swSync[ch]) && $stable(vehSync)
				&& $stable(cfgReg[ch]) && $stable(limitReg[ch]) && $stable(shedSync)
				&& $stable(keySync) && $stable(currSync[ch]) && $stable(chState[ch])
				|-> $stable(allOk[ch]))
				else $error("channel depends on the other channel");
			AST_KEY: assert property (!keySync |=> !loadOn[ch])
				else $error("output on without permitted key state");
			AST_AND: assert property (loadOn[ch] |-> $past(allOk[ch]))
				else $error("output on without every permit");
			AST_SHED: assert property (shedOn[ch] |=> !loadOn[ch])
				else $error("output not shed at its level");
		end
	endgenerate
endmodule : iaoc_top

// File: test/iaoc_bench.sv
/*
 iaoc_bench: self-checking bench of the two-channel interlocked output controller.
 Assumes: zero-wait APB slave, three edges from pin change to loadOn.
*/
`timescale 1ns/1ps
module iaoc_bench;
	import iaoc_pkg::*;
	typedef struct {string name; logic [32:0] exp;} iaoc_note_t;

	logic clock, rst, psel, penable, pwrite, pready, pslverr, ignitionKeyOn, probe;
	logic parkBrake, doorOpen, powerTakeoffEngaged, engineRunning;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] vehicleSpeed, transmissionGear;
	logic [1:0] shedRequest, switchOn, loadOn;
	logic [NUM_CH-1:0][7:0] demand, loadCurrent;
	iaoc_vehicle_t veh, v;
	iaoc_note_t qRd[$], qOut[$], note;
	logic [4:0] sel[2];
	logic [7:0] sp[2], gr[2];
	int n_fail, n_checks, cycles, i, c;

	iaoc_top i_iaoc_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .switchOn(switchOn), .ignitionKeyOn(ignitionKeyOn),
		.parkBrake(parkBrake), .doorOpen(doorOpen), .powerTakeoffEngaged(powerTakeoffEngaged),
		.engineRunning(engineRunning), .vehicleSpeed(vehicleSpeed),
		.transmissionGear(transmissionGear), .loadCurrent(loadCurrent),
		.shedRequest(shedRequest), .loadOn(loadOn));

	iaoc_load_model i_iaoc_load_model (.clock(clock), .veh(veh), .demand(demand),
		.loadOn(loadOn), .parkBrake(parkBrake), .doorOpen(doorOpen),
		.powerTakeoffEngaged(powerTakeoffEngaged), .engineRunning(engineRunning),
		.vehicleSpeed(vehicleSpeed), .transmissionGear(transmissionGear),
		.loadCurrent(loadCurrent));

	// clock generator
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// monitor: read answers and probed outputs against the oldest note
	always @(posedge clock) begin
		cycles++;
		if (psel && penable && pready && !pwrite) begin
			note = qRd.pop_front();
			check(note.name, {pslverr, prdata}, note.exp);
		end
		if (probe) begin
			note = qOut.pop_front();
			check(note.name, {31'h0, loadOn}, note.exp);
		end
		if (cycles == 6000) begin
			n_fail++;
			results();
		end
	end

	// one apb transfer, released after pready is seen high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb

	task automatic rd(input logic [11:0] addr, input logic [32:0] exp);
		qRd.push_back('{"apb read", exp});
		apb(1'b0, addr, 32'h0);
	endtask : rd

	task automatic wcfg(input int ch, input logic [4:0] s, input logic l, input logic [1:0] p,
		input logic [7:0] spd, input logic [7:0] gear);
		apb(1'b1, ch ? OFF_CFG1 : OFF_CFG0, {8'h00, gear, spd, p, l, s});
	endtask : wcfg

	// wait out the pin latency, then note and probe the outputs
	task automatic settle(input logic [1:0] exp);
		repeat (5) @(posedge clock);
		qOut.push_back('{"loadOn", {31'h0, exp}});
		probe <= 1'b1;
		@(posedge clock);
		probe <= 1'b0;
	endtask : settle

	// expected interlock result of one selector
	function automatic logic condRef(input logic [4:0] s, input iaoc_vehicle_t x,
		input logic [7:0] spd, input logic [7:0] gear);
		case (s)
			5'h00: condRef = 1'b1;
			5'h01: condRef = x.parkBrake;
			5'h02: condRef = !x.parkBrake;
			5'h03: condRef = x.doorOpen;
			5'h04: condRef = !x.doorOpen;
			5'h05: condRef = x.powerTakeoffEngaged;
			5'h06: condRef = !x.powerTakeoffEngaged;
			5'h07: condRef = x.engineRunning;
			5'h08: condRef = !x.engineRunning;
			5'h09: condRef = x.speed > spd;
			5'h0A: condRef = x.speed < spd;
			5'h0B: condRef = x.speed == 8'h00;
			5'h0C: condRef = x.speed != 8'h00;
			5'h0D: condRef = x.gear > gear;
			5'h0E: condRef = x.gear < gear;
			5'h0F: condRef = x.gear == 8'h7D;
			5'h10: condRef = x.gear != 8'h7D;
			default: condRef = 1'b0;
		endcase
	endfunction : condRef

	// main sequence
	initial begin
		void'($urandom(32'h0793C5B5));
		{psel, penable, pwrite, probe, ignitionKeyOn} = 5'h00;
		{paddr, pwdata, switchOn, shedRequest} = '0;
		veh = '0;
		demand = {8'h0A, 8'h0A};
		rst = 1'b1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// reset values and an unmapped place
		for (c = 0; c < 2; c++) begin
			rd(12'(c * 8), {9'h000, 8'h7D, 8'h1E, 2'h1, 1'b0, 5'h0A});
			rd(12'(c * 8 + 4), {25'h0, 8'hC8});
		end
		rd(12'h018, {1'b1, 32'h0});
		settle(2'b00);
		// defaults: stopped is below the speed threshold
		ignitionKeyOn <= 1'b1;
		switchOn <= 2'b11;
		settle(2'b11);
		rd(OFF_INPUTS, {1'b0, 32'h00100000});
		// every selector on channel 0, random selector on channel 1
		for (i = 0; i < 72; i++) begin
			sel[0] = 5'(i % 18);
			sel[1] = 5'($urandom_range(17));
			for (c = 0; c < 2; c++) begin
				sp[c] = 8'($urandom_range(100));
				gr[c] = (i % 3 == 0) ? 8'h7D : 8'($urandom_range(250));
				wcfg(c, sel[c], 1'b0, 2'h1, sp[c], gr[c]);
			end
			v = 20'($urandom);
			if (i % 4 == 1) v.speed = sp[0] + 8'($urandom_range(2)) - 8'h01;
			if (i % 4 == 2) v.gear = gr[0] + 8'($urandom_range(2)) - 8'h01;
			if (i % 4 == 3) v.speed = 8'h00;
			veh <= v;
			settle({condRef(sel[1], v, sp[1], gr[1]), condRef(sel[0], v, sp[0], gr[0])});
		end
		// latched drop on channel 0, plain drop on channel 1
		wcfg(0, COND_ENG_RUN, 1'b1, 2'h1, 8'h1E, 8'h7D);
		wcfg(1, COND_ENG_RUN, 1'b0, 2'h1, 8'h1E, 8'h7D);
		veh <= '0;
		switchOn <= 2'b00;
		settle(2'b00);
		veh.engineRunning <= 1'b1;
		switchOn <= 2'b11;
		settle(2'b11);
		veh.engineRunning <= 1'b0;
		settle(2'b00);
		rd(OFF_STATUS, {1'b0, 32'h00001012});
		veh.engineRunning <= 1'b1;
		settle(2'b10);
		switchOn <= 2'b10;
		settle(2'b10);
		switchOn <= 2'b11;
		settle(2'b11);
		// first forward gear lies above neutral
		veh.gear <= GEAR_FIRST_FWD;
		wcfg(0, COND_GEAR_ABOVE, 1'b0, 2'h1, 8'h1E, GEAR_NEUTRAL);
		settle(2'b11);
		// virtual fuse at its boundary
		wcfg(0, COND_NONE, 1'b0, 2'h0, 8'h1E, 8'h7D);
		wcfg(1, COND_NONE, 1'b0, 2'h1, 8'h1E, 8'h7D);
		apb(1'b1, OFF_LIM0, 32'h00000064);
		rd(OFF_LIM0, {25'h0, 8'h64});
		demand[0] <= 8'h64;
		settle(2'b11);
		demand[0] <= 8'h65;
		settle(2'b10);
		rd(OFF_STATUS, {1'b0, 32'h0000191C});
		demand[0] <= 8'h0A;
		settle(2'b10);
		switchOn <= 2'b10;
		settle(2'b10);
		switchOn <= 2'b11;
		settle(2'b11);
		// shed levels: channel 0 at level 1, channel 1 at level 3
		wcfg(0, COND_NONE, 1'b0, 2'h1, 8'h1E, 8'h7D);
		wcfg(1, COND_NONE, 1'b0, 2'h3, 8'h1E, 8'h7D);
		for (i = 0; i < 4; i++) begin
			shedRequest <= 2'(i);
			settle({1'(i < 3), 1'(i < 1)});
		end
		wcfg(1, COND_NONE, 1'b0, 2'h0, 8'h1E, 8'h7D);
		settle(2'b10);
		shedRequest <= 2'h0;
		settle(2'b11);
		// key out of ignition drops both
		ignitionKeyOn <= 1'b0;
		settle(2'b00);
		ignitionKeyOn <= 1'b1;
		settle(2'b11);
		results();
	end
endmodule : iaoc_bench

// File: test/iaoc_load_model.sv
/*
 iaoc_load_model: far side of the controller, vehicle sensor harness and the load driver.
 Assumes: bench drives the sensor struct and load demand after rising edges.
*/
`timescale 1ns/1ps
module iaoc_load_model (
	// clock
	input wire logic clock,
	// bench side
	input iaoc_pkg::iaoc_vehicle_t veh,
	input wire logic [iaoc_pkg::NUM_CH-1:0][7:0] demand,
	// device side
	input wire logic [iaoc_pkg::NUM_CH-1:0] loadOn,
	output logic parkBrake,
	output logic doorOpen,
	output logic powerTakeoffEngaged,
	output logic engineRunning,
	output logic [7:0] vehicleSpeed,
	output logic [7:0] transmissionGear,
	output logic [iaoc_pkg::NUM_CH-1:0][7:0] loadCurrent
);
	import iaoc_pkg::*;

	// sensor levels go straight to the pins
	assign parkBrake = veh.parkBrake;
	assign doorOpen = veh.doorOpen;
	assign powerTakeoffEngaged = veh.powerTakeoffEngaged;
	assign engineRunning = veh.engineRunning;
	assign vehicleSpeed = veh.speed;
	assign transmissionGear = veh.gear;

	// a load draws current only while driven, measured one cycle late
	always_ff @(posedge clock) begin
		for (int c = 0; c < NUM_CH; c++) begin
			loadCurrent[c] <= loadOn[c] ? demand[c] : 8'h00;
		end
	end
endmodule : iaoc_load_model
